// ==== adc_clock_conversion_control.sv ====
// successive-approximation converter control with bit-period clock selection
// assumes an analog comparator outside; rc clock arrives asynchronously as a pin
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"

// Function
// - ten-bit SAR result into result byte pair
// - selected channel muxed into one sample-hold
// - software selects internal or external reference
// - interrupt request when a conversion completes
// - completion interrupt wakes device from sleep when the rc clock is selected
// - clock select decode: dividers or rc clock
module adc_clock_conversion_control #(
	parameter int CONV_BITS = `CONV_BITS,
	parameter int CHAN_BITS = `CHAN_BITS
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic enable_i,
	input wire logic start_i,
	input wire logic [2:0] conv_clock_select_i,
	input wire logic [CHAN_BITS-1:0] chan_sel_i,
	input wire logic ref_ext_sel_i,
	input wire logic int_enable_i,
	input wire logic done_clear_i,
	input wire logic sleep_i,
	input wire logic dedicated_rc_clock_i,
	input wire logic comp_i,
	output logic [CHAN_BITS-1:0] mux_chan_o,
	output logic sample_o,
	output logic ref_ext_o,
	output logic [CONV_BITS-1:0] dac_trial_o,
	output logic busy_o,
	output logic done_o,
	output logic irq_o,
	output logic wake_o,
	output logic [7:0] result_high_byte_o,
	output logic [7:0] result_low_byte_o
);
	import adc_ctrl_pkg::*;

	// widths the result pair or the mux cannot carry are refused at elaboration
	if (CONV_BITS < 2 || CONV_BITS > 16) begin : g_bad_conv_bits
		$error("CONV_BITS out of range");
	end
	if (CHAN_BITS < 1 || CHAN_BITS > 8) begin : g_bad_chan_bits
		$error("CHAN_BITS out of range");
	end

	typedef struct packed {
		conv_state_t st;
		logic [1:0] rc_sync;
		logic rc_prev;
		logic [5:0] div_cnt;
		logic [3:0] acq_cnt;
		logic [CONV_BITS-1:0] trial;
		logic [CONV_BITS-1:0] bit_mask;
		logic [CHAN_BITS-1:0] chan;
		logic sample;
		logic ref_ext;
		logic busy;
		logic done;
		logic irq;
		logic wake;
		logic [15:0] result;
		logic [1:0] comp_sync;
		logic [1:0] settle;
		logic step_due;
	} state_t;

	state_t cur_ff;
	state_t nxt_ff;

	// bit period enable from the 3-bit select code
	function automatic logic [5:0] div_limit(input logic [2:0] sel);
		case (sel)
			`SEL_DIV2: div_limit = 6'h01;
			`SEL_DIV4: div_limit = 6'h03;
			`SEL_DIV8: div_limit = 6'h07;
			`SEL_DIV16: div_limit = 6'h0F;
			`SEL_DIV32: div_limit = 6'h1F;
			`SEL_DIV64: div_limit = 6'h3F;
			default: div_limit = 6'h00;
		endcase
	endfunction : div_limit

	logic use_rc;
	logic tick;
	assign use_rc = (conv_clock_select_i[1:0] == `RC_SEL_LOW);

	always_comb begin
		logic [CONV_BITS-1:0] kept;
		kept = '0;
		nxt_ff = cur_ff;
		nxt_ff.rc_sync = {cur_ff.rc_sync[0], dedicated_rc_clock_i};
		nxt_ff.comp_sync = {cur_ff.comp_sync[0], comp_i};
		nxt_ff.rc_prev = cur_ff.rc_sync[1];
		nxt_ff.ref_ext = ref_ext_sel_i;
		nxt_ff.irq = 1'b0;
		nxt_ff.wake = 1'b0;
		if (cur_ff.settle != 2'h0)
			nxt_ff.settle = cur_ff.settle - 2'h1;
		// system divisions stall in sleep, so only the rc edge ticks there
		if (use_rc) begin
			tick = cur_ff.rc_sync[1] & ~cur_ff.rc_prev;
			nxt_ff.div_cnt = 6'h00;
		end else if (sleep_i) begin
			tick = 1'b0;
		end else begin
			tick = (cur_ff.div_cnt >= div_limit(conv_clock_select_i));
			nxt_ff.div_cnt = tick ? 6'h00 : cur_ff.div_cnt + 6'h01;
		end
		if (done_clear_i)
			nxt_ff.done = 1'b0;
		case (cur_ff.st)
			ST_IDLE: begin
				if (enable_i && start_i) begin
					nxt_ff.st = ST_ACQ;
					nxt_ff.chan = chan_sel_i;
					nxt_ff.sample = 1'b1;
					nxt_ff.busy = 1'b1;
					nxt_ff.acq_cnt = 4'h0;
					nxt_ff.div_cnt = 6'h00;
				end
			end
			ST_ACQ: begin
				if (tick) begin
					nxt_ff.acq_cnt = cur_ff.acq_cnt + 4'h1;
					if (cur_ff.acq_cnt + 4'h1 >= `ACQ_PERIODS) begin
						nxt_ff.st = ST_CONV;
						nxt_ff.sample = 1'b0; // hold stage frozen for the conversion
						nxt_ff.bit_mask = {1'b1, {(CONV_BITS-1){1'b0}}};
						nxt_ff.trial = {1'b1, {(CONV_BITS-1){1'b0}}};
						nxt_ff.settle = `COMP_SETTLE;
						nxt_ff.step_due = 1'b0;
					end
				end
			end
			ST_CONV: begin
				if (tick)
					nxt_ff.step_due = 1'b1;
				// a due step waits until the synced comparator has seen this trial;
				// at the fastest divider that stretches each bit period
				if ((tick || cur_ff.step_due) && cur_ff.settle == 2'h0) begin
					nxt_ff.step_due = 1'b0;
					nxt_ff.settle = `COMP_SETTLE;
					// comparator high means the trial overshoots: drop that bit
					kept = cur_ff.comp_sync[1] ? (cur_ff.trial & ~cur_ff.bit_mask) : cur_ff.trial;
					nxt_ff.bit_mask = cur_ff.bit_mask >> 1;
					nxt_ff.trial = kept | (cur_ff.bit_mask >> 1);
					if (cur_ff.bit_mask[0]) begin
						nxt_ff.st = ST_DONE;
						nxt_ff.trial = kept;
						nxt_ff.result = 16'(kept);
						nxt_ff.busy = 1'b0;
						nxt_ff.done = 1'b1; // set beats clear
						nxt_ff.irq = int_enable_i;
						nxt_ff.wake = int_enable_i & sleep_i;
					end
				end
			end
			ST_DONE: nxt_ff.st = ST_IDLE;
			default: nxt_ff.st = ST_IDLE;
		endcase
		if (!enable_i && cur_ff.st != ST_IDLE) begin
			nxt_ff.st = ST_IDLE;
			nxt_ff.busy = 1'b0;
			nxt_ff.sample = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			cur_ff <= '0;
			cur_ff.st <= ST_IDLE;
			cur_ff.rc_sync <= `RC_SYNC_RESET;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign mux_chan_o = cur_ff.chan;
	assign sample_o = cur_ff.sample;
	assign ref_ext_o = cur_ff.ref_ext;
	assign dac_trial_o = cur_ff.trial;
	assign busy_o = cur_ff.busy;
	assign done_o = cur_ff.done;
	assign irq_o = cur_ff.irq;
	assign wake_o = cur_ff.wake;
	assign result_high_byte_o = cur_ff.result[15:8];
	assign result_low_byte_o = cur_ff.result[7:0];

	property p_done_with_busy;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		$rose(done_o) |-> $fell(busy_o) && $changed(cur_ff.st);
	endproperty
	a_done_with_busy: assert property (p_done_with_busy) else $error("done rose without busy fall");

	property p_irq_needs_done;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		irq_o |-> done_o && $past(int_enable_i) && !busy_o;
	endproperty
	a_irq_needs_done: assert property (p_irq_needs_done) else $error("irq without completion");

	property p_wake_in_sleep;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		wake_o |-> irq_o && $past(sleep_i);
	endproperty
	a_wake_in_sleep: assert property (p_wake_in_sleep) else $error("wake outside sleep");

	property p_irq_one_cycle;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		irq_o |=> !irq_o;
	endproperty
	a_irq_one_cycle: assert property (p_irq_one_cycle) else $error("irq longer than a cycle");

	property p_chan_stable;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		busy_o && $past(busy_o) |-> $stable(mux_chan_o);
	endproperty
	a_chan_stable: assert property (p_chan_stable) else $error("channel changed mid conversion");

	property p_ref_follow;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		##1 ref_ext_o == $past(ref_ext_sel_i);
	endproperty
	a_ref_follow: assert property (p_ref_follow) else $error("reference select not followed");

	property p_div2_tick;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		conv_clock_select_i == `SEL_DIV2 && !sleep_i && cur_ff.div_cnt == 6'h01 |-> tick;
	endproperty
	a_div2_tick: assert property (p_div2_tick) else $error("divide by two tick missing");

	property p_no_sys_tick_sleep;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		sleep_i && !use_rc |-> !tick;
	endproperty
	a_no_sys_tick_sleep: assert property (p_no_sys_tick_sleep) else $error("system tick during sleep");

	property p_result_low;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		$rose(done_o) |-> result_high_byte_o[7:2] == 6'h00;
	endproperty
	a_result_low: assert property (p_result_low) else $error("result wider than ten bits");

	c_conv_done: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) $rose(done_o));
	c_irq: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) irq_o);
	c_wake: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) wake_o);
	c_rc_conv: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) use_rc && $rose(done_o));
endmodule : adc_clock_conversion_control

// ==== adc_ctrl_defs.svh ====
// constants for the converter control block: clock select codes, widths, timing
// assumes the includer needs no other definitions
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH
`define CONV_BITS 10
`define CHAN_BITS 3
`define SEL_DIV2 3'h0
`define SEL_DIV4 3'h4
`define SEL_DIV8 3'h1
`define SEL_DIV16 3'h5
`define SEL_DIV32 3'h2
`define SEL_DIV64 3'h6
`define RC_SEL_LOW 2'h3
`define ACQ_PERIODS 4'h2
`define RC_SYNC_RESET 2'h0
`define COMP_SETTLE 2'h2
`endif

// ==== adc_ctrl_pkg.sv ====
// types for the converter control block
// assumes adc_ctrl_defs.svh holds the numeric constants
package adc_ctrl_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ACQ = 4'b0010,
		ST_CONV = 4'b0100,
		ST_DONE = 4'b1000
	} conv_state_t;
endpackage : adc_ctrl_pkg

// ==== adc_chan_model.sv ====
// analog side model: channel levels seen through the mux and a comparator
// assumes the control block drives channel and trial word from registers
`timescale 1ns/1ps
module adc_chan_model (
	input wire logic [2:0] chan_i,
	input wire logic [9:0] trial_i,
	input wire logic [9:0] level_i [8],
	output logic comp_o
);
	// high while the held input sits below the trial level
	assign comp_o = (trial_i > level_i[chan_i]);
endmodule : adc_chan_model

// ==== adc_clock_conversion_control_tb.sv ====
// self-checking bench for the converter control block
// assumes the analog model answers the comparator at once
`timescale 1ns/1ps
module adc_clock_conversion_control_tb;
	logic ref_clk_i = 1'b0, rstn_i = 1'b0, enable_i = 1'b0, start_i = 1'b0, ref_ext_sel_i = 1'b0;
	logic int_enable_i = 1'b0, done_clear_i = 1'b0, sleep_i = 1'b0, rc_clk = 1'b0, comp;
	logic [2:0] sel = 3'h0, chan = 3'h0, mux_chan;
	logic [9:0] levels [8] = '{default: 10'h000};
	logic [9:0] trial;
	logic [7:0] hi, lo;
	logic sample, ref_ext, busy, done, irq, wake;
	logic [31:0] lfsr_ff = 32'h26F8;
	int num_errors = 0;
	int tests_run = 0;
	adc_clock_conversion_control i_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .enable_i(enable_i),
		.start_i(start_i), .conv_clock_select_i(sel), .chan_sel_i(chan), .ref_ext_sel_i(ref_ext_sel_i),
		.int_enable_i(int_enable_i), .done_clear_i(done_clear_i), .sleep_i(sleep_i),
		.dedicated_rc_clock_i(rc_clk), .comp_i(comp), .mux_chan_o(mux_chan), .sample_o(sample),
		.ref_ext_o(ref_ext), .dac_trial_o(trial), .busy_o(busy), .done_o(done), .irq_o(irq),
		.wake_o(wake), .result_high_byte_o(hi), .result_low_byte_o(lo));
	adc_chan_model i_model (.chan_i(mux_chan), .trial_i(trial), .level_i(levels), .comp_o(comp));
	initial forever #50 ref_clk_i = ~ref_clk_i;
	// rc oscillator is free running at one seventh of the system clock rate, its edges on system clock edges
	initial forever #350 rc_clk = ~rc_clk;
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up();
		$display("errors=%0d checks=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : wrap_up
	task automatic conv(input logic [2:0] s, input logic [9:0] lvl, input logic slp);
		int n;
		int d;
		logic [2:0] c;
		logic ie;
		lfsr_ff = nxt(lfsr_ff);
		c = lfsr_ff[2:0];
		ie = lfsr_ff[5];
		d = (s[1:0] == 2'h3) ? 0 : (2 << {s[1], s[0], s[2]});
		@(posedge ref_clk_i);
		sel <= s; chan <= c; int_enable_i <= ie; sleep_i <= slp; ref_ext_sel_i <= lfsr_ff[7];
		levels[c] <= lvl;
		start_i <= 1'b1;
		@(posedge ref_clk_i);
		start_i <= 1'b0;
		#1;
		check({busy, sample, mux_chan}, {2'h3, c});
		check(ref_ext, lfsr_ff[7]);
		// second start mid-run must be ignored, channel kept
		@(posedge ref_clk_i);
		start_i <= 1'b1;
		chan <= ~c;
		@(posedge ref_clk_i);
		start_i <= 1'b0;
		n = 2;
		while (done !== 1'b1 && n < 2000) begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end
		check({busy, mux_chan}, {1'b0, c});
		check({hi, lo}, {6'h00, lvl});
		check({irq, wake}, {ie, ie & slp});
		// below three cycles a bit step waits for the comparator synchroniser
		if (d != 0) check(n >= 12 * d - 2 && n <= 2 * d + 11 * ((d < 3) ? 3 : d) + 2, 1'b1);
		else check(n < 2000, 1'b1);
		@(posedge ref_clk_i);
		done_clear_i <= 1'b1;
		#1;
		check({irq, done}, 2'h1);
		@(posedge ref_clk_i);
		done_clear_i <= 1'b0;
		#1;
		check(done, 1'b0);
		$display("test sel=%h lvl=%h done", s, lvl);
	endtask : conv
	initial begin
		repeat (60000) @(posedge ref_clk_i);
		num_errors++;
		wrap_up();
	end
	initial begin
		repeat (4) @(posedge ref_clk_i);
		#1;
		check({busy, done, irq, wake, sample, hi, lo}, 21'h0);
		repeat (12) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		enable_i <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			lfsr_ff = nxt(lfsr_ff);
			conv(i[2:0], lfsr_ff[17:8], 1'b0);
		end
		conv(3'h0, 10'h000, 1'b0);
		conv(3'h0, 10'h3FF, 1'b0);
		conv(3'h3, 10'h2AA, 1'b1);
		conv(3'h7, 10'h155, 1'b1);
		// a system-derived bit period stops in sleep: the run waits in acquisition
		@(posedge ref_clk_i);
		sel <= 3'h4;
		sleep_i <= 1'b1;
		int_enable_i <= 1'b1;
		start_i <= 1'b1;
		@(posedge ref_clk_i);
		start_i <= 1'b0;
		repeat (200) @(posedge ref_clk_i);
		#1;
		check({busy, done, sample}, 3'h5);
		@(posedge ref_clk_i);
		sleep_i <= 1'b0;
		repeat (60) @(posedge ref_clk_i);
		#1;
		check({busy, done, irq, wake}, 4'h4);
		// dropping enable mid-run releases the hold stage and busy
		@(posedge ref_clk_i);
		done_clear_i <= 1'b1;
		start_i <= 1'b1;
		@(posedge ref_clk_i);
		done_clear_i <= 1'b0;
		start_i <= 1'b0;
		#1;
		check({busy, sample, done}, 3'h6);
		@(posedge ref_clk_i);
		enable_i <= 1'b0;
		@(posedge ref_clk_i);
		#1;
		check({busy, sample, done}, 3'h0);
		@(posedge ref_clk_i);
		enable_i <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			lfsr_ff = nxt(lfsr_ff);
			conv(lfsr_ff[2:0], lfsr_ff[19:10], 1'b0);
		end
		wrap_up();
	end
endmodule : adc_clock_conversion_control_tb
